// ---- rvip_defs.svh ----
// Offsets, field positions, reset values and timing counts
`ifndef RVIP_DEFS_SVH
`define RVIP_DEFS_SVH
// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define RVIP_OFF_CFG      8'h00
`define RVIP_OFF_PRIO     8'h04
`define RVIP_OFF_FLAGS    8'h08
`define RVIP_OFF_STATUS   8'h0C
`define RVIP_OFF_OPTION   8'h10
`define RVIP_OFF_RAMMAP   8'h14
`define RVIP_OFF_RATE     8'h18
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define RVIP_CFG_WDDIS    2
`define RVIP_PRIO_BOOT    7
`define RVIP_PRIO_SPEC    6
`define RVIP_PRIO_MODEA   5
`define RVIP_FLG_IMASK    0
`define RVIP_FLG_XMASK    1
`define RVIP_FLG_STOPDIS  2
`define RVIP_OPT_IRQEDGE  5
`define RVIP_OPT_DLY      4
`define RVIP_OPT_CME      3
// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define RVIP_CFG_RST      8'h0F
`define RVIP_PSEL_RST     4'h6
`define RVIP_PRIO_LOW_RST 5'h06
`define RVIP_OPT_RST      8'h10
`define RVIP_RAMMAP_RST   8'h01
`define RVIP_RATE_RST     8'h04
`define RVIP_TCNT_RST     16'h0000
`define RVIP_OC_RST       16'hFFFF
`define RVIP_SSTAT_RST    8'hC0
`define RVIP_VEC_NORM     8'hFF
`define RVIP_VEC_SPEC     8'hBF
`define RVIP_VLO_POR      8'hFE
`define RVIP_VLO_CLK      8'hFC
`define RVIP_VLO_WD       8'hFA
// ------------------------------------------------------------
// Timing counts in E-clock cycles, then interrupt select codes
// ------------------------------------------------------------
`define RVIP_HOLD_CYC     3'd4
`define RVIP_FETCH_CYC    2'd3
`define RVIP_SEL_NMI      5'h10
`define RVIP_SEL_ILL      5'h11
`define RVIP_SEL_SWI      5'h12
`define RVIP_SEL_NONE     5'h1F
`endif

// ---- rvip_pkg.sv ----
// Types shared by the reset vector and priority logic
package rvip_pkg;
  typedef enum logic [1:0] {
    RVIP_HOLD  = 2'b00,
    RVIP_FETCH = 2'b01,
    RVIP_RUN   = 2'b10
  } rvip_state_t;
  typedef enum logic [1:0] {
    RVIP_POR = 2'b00,
    RVIP_CLK = 2'b01,
    RVIP_WD  = 2'b10
  } rvip_cause_t;
endpackage

// ---- rvip_core.sv ----
// Reset vector selection, reset-state init and interrupt priority
//
// Our own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "rvip_defs.svh"
// Contract
// - Normal modes: vector FFFE, FFFC or FFFA by reset cause.
// - Special modes: vector BFFE, BFFC or BFFA by the same causes.
// - Watchdog timeout forces reset only when the disable bit is 0.
// - After reset, three vector fetch cycles, then execution starts.
// - Reset sets both interrupt masks and the stop-disable flag.
// - Reset loads the RAM/register map register with 01.
// - Reset clears timer count and prescaler, compares load FFFF.
// - Reset clears compare pin control, capture edges, timer flags, enables.
// - Reset selects compare-5 and clears its pin action bits.
// - Reset clears periodic flag, its enable and its rate bits.
// - Reset disables the pulse counter, its pin a plain input.
// - Watchdog enabled out of reset iff disable bit clear; shortest rate.
// - Reset sets serial rate 04, masks and disables serial, 8-bit chars.
// - After reset transmit flags read 1, receive flags read 0.
// - Reset disables SPI, pins return to general I/O.
// - Reset loads priority select 0110 and level-sensitive pin request.
// - Mode bits capture mode pins at reset release; special writes change. Here only at system reset release.
// - Reset sets startup delay, clears clock-loss enable, EEPROM programming.
// - Non-maskable order: reset pin, clock loss, watchdog, pin, illegal, trap.
// - Default maskable order: pin request first, serial last.
// - Selected source promoted above others, masks still apply.
// - Priority register writes accepted only while the global mask is set.
// - Priority select codes map to sources; code 0101 acts as pin request.
module rvip_core (
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        porPin,
  input  wire logic        clockLossReq,
  input  wire logic        watchdogTimeout,
  input  wire logic        modePinA,
  input  wire logic        modePinB,
  input  wire logic [14:0] maskReq,
  input  wire logic        nonmaskablePinRequest,
  input  wire logic        illegalOp,
  input  wire logic        softwareTrap,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output logic             cpuReset,
  output logic             vectorFetch,
  output logic [15:0]      vectorAddr,
  output logic             intValid,
  output logic [4:0]       intSel,
  output logic             stopInhibit,
  output logic             wdEnable,
  output logic [1:0]       wdRate,
  output logic             clockLossEnable,
  output logic             oscStartupDelay,
  output logic             periphInit,
  output logic [15:0]      timerCountInit,
  output logic [15:0]      compareInit,
  output logic [7:0]       serialStatusInit
);
  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  logic [4:0] syncA_reg;
  logic [4:0] syncB_reg;
  always_ff @(posedge mclk) begin
    syncA_reg <= {modePinB, modePinA, watchdogTimeout, clockLossReq,
                  porPin};
    syncB_reg <= syncA_reg;
  end
  logic porSync;
  logic clkSync;
  logic wdSync;
  assign porSync = syncB_reg[0];
  assign clkSync = syncB_reg[1];
  assign wdSync  = syncB_reg[2];

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [7:0] cfg_reg;
  logic [7:0] prio_reg;
  logic [2:0] modeBits_reg;
  logic [4:0] prioLow_reg;
  logic [2:0] flags_reg;
  logic [7:0] option_reg;
  logic [7:0] ramMap_reg;
  logic [7:0] rate_reg;
  logic       wdEnable_reg;
  rvip_pkg::rvip_state_t state_reg;
  rvip_pkg::rvip_cause_t cause_reg;
  logic [2:0] cnt_reg;
  logic       srstDly_reg;

  // ------------------------------------------------------------
  // Reset sequencer
  // ------------------------------------------------------------
  logic trigClk;
  logic trigWd;
  logic trigAny;
  logic inReset;
  assign trigClk = clkSync && option_reg[`RVIP_OPT_CME];
  assign trigWd  = wdSync && wdEnable_reg;
  assign trigAny = porSync || trigClk || trigWd;
  assign inReset = srst || (state_reg == rvip_pkg::RVIP_HOLD);

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_reg <= rvip_pkg::RVIP_HOLD;
      cause_reg <= rvip_pkg::RVIP_POR;
      cnt_reg   <= 3'd0;
    end else if (trigAny && state_reg != rvip_pkg::RVIP_HOLD) begin
      state_reg <= rvip_pkg::RVIP_HOLD;
      cnt_reg   <= 3'd0;
      if (porSync) begin
        cause_reg <= rvip_pkg::RVIP_POR;
      end else if (trigClk) begin
        cause_reg <= rvip_pkg::RVIP_CLK;
      end else begin
        cause_reg <= rvip_pkg::RVIP_WD;
      end
    end else begin
      case (state_reg)
        rvip_pkg::RVIP_HOLD: begin
          if (cnt_reg == `RVIP_HOLD_CYC - 3'd1) begin
            state_reg <= rvip_pkg::RVIP_FETCH;
            cnt_reg   <= 3'd0;
          end else begin
            cnt_reg <= cnt_reg + 3'd1;
          end
        end
        rvip_pkg::RVIP_FETCH: begin
          if (cnt_reg == {1'b0, `RVIP_FETCH_CYC} - 3'd1) begin
            state_reg <= rvip_pkg::RVIP_RUN;
            cnt_reg   <= 3'd0;
          end else begin
            cnt_reg <= cnt_reg + 3'd1;
          end
        end
        rvip_pkg::RVIP_RUN: begin
          cnt_reg <= 3'd0;
        end
        default: begin
          state_reg <= rvip_pkg::RVIP_HOLD;
          cnt_reg   <= 3'd0;
        end
      endcase
    end
  end

  logic [15:0] vecNext;
  always_comb begin
    vecNext[15:8] = prio_reg[`RVIP_PRIO_SPEC] ? `RVIP_VEC_SPEC
                                              : `RVIP_VEC_NORM;
    case (cause_reg)
      rvip_pkg::RVIP_POR: vecNext[7:0] = `RVIP_VLO_POR;
      rvip_pkg::RVIP_CLK: vecNext[7:0] = `RVIP_VLO_CLK;
      rvip_pkg::RVIP_WD:  vecNext[7:0] = `RVIP_VLO_WD;
      default:            vecNext[7:0] = `RVIP_VLO_POR;
    endcase
  end

  always_ff @(posedge mclk) begin
    cpuReset    <= inReset;
    vectorFetch <= !srst && state_reg == rvip_pkg::RVIP_FETCH;
    vectorAddr  <= srst ? 16'h0000 : vecNext;
    srstDly_reg <= srst;
  end

  // ------------------------------------------------------------
  // AXI4-Lite write path
  // ------------------------------------------------------------
  logic [7:0]  awAddr_reg;
  logic        awHeld_reg;
  logic [31:0] wData_reg;
  logic [3:0]  wStrb_reg;
  logic        wHeld_reg;
  logic        doWrite;
  logic        wrHit;
  logic [7:0]  wByte;
  assign doWrite = awHeld_reg && wHeld_reg && !bvalid;
  assign wByte   = wData_reg[7:0];

  always_ff @(posedge mclk) begin
    if (srst) begin
      awHeld_reg <= 1'b0;
      wHeld_reg  <= 1'b0;
      awready    <= 1'b0;
      wready     <= 1'b0;
      bvalid     <= 1'b0;
      bresp      <= 2'b00;
      awAddr_reg <= 8'h00;
      wData_reg  <= 32'h0000_0000;
      wStrb_reg  <= 4'h0;
    end else begin
      awready <= !awHeld_reg && !(awvalid && awready);
      wready  <= !wHeld_reg && !(wvalid && wready);
      if (awvalid && awready) begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= awaddr;
      end
      if (wvalid && wready) begin
        wHeld_reg <= 1'b1;
        wData_reg <= wdata;
        wStrb_reg <= wstrb;
      end
      if (doWrite) begin
        awHeld_reg <= 1'b0;
        wHeld_reg  <= 1'b0;
        bvalid     <= 1'b1;
        bresp      <= wrHit ? 2'b00 : 2'b10;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    case ({awAddr_reg[7:2], 2'b00})
      `RVIP_OFF_CFG, `RVIP_OFF_PRIO, `RVIP_OFF_FLAGS, `RVIP_OFF_STATUS,
      `RVIP_OFF_OPTION, `RVIP_OFF_RAMMAP, `RVIP_OFF_RATE: wrHit = 1'b1;
      default: wrHit = 1'b0;
    endcase
  end

  logic wrCfg;
  logic wrPrio;
  logic wrFlags;
  logic wrOpt;
  logic wrMap;
  logic wrRate;
  logic wrEn;
  assign wrEn    = doWrite && wStrb_reg[0];
  assign wrCfg   = wrEn && {awAddr_reg[7:2], 2'b00} == `RVIP_OFF_CFG;
  assign wrPrio  = wrEn && {awAddr_reg[7:2], 2'b00} == `RVIP_OFF_PRIO;
  assign wrFlags = wrEn && {awAddr_reg[7:2], 2'b00} == `RVIP_OFF_FLAGS;
  assign wrOpt   = wrEn && {awAddr_reg[7:2], 2'b00} == `RVIP_OFF_OPTION;
  assign wrMap   = wrEn && {awAddr_reg[7:2], 2'b00} == `RVIP_OFF_RAMMAP;
  assign wrRate  = wrEn && {awAddr_reg[7:2], 2'b00} == `RVIP_OFF_RATE;

  // ------------------------------------------------------------
  // Register state and reset-state init
  // ------------------------------------------------------------
  // Configuration survives internal resets; only the system reset loads it
  always_ff @(posedge mclk) begin
    if (srst) begin
      cfg_reg <= `RVIP_CFG_RST;
    end else if (wrCfg) begin
      cfg_reg <= wByte;
    end
  end

  always_ff @(posedge mclk) begin
    if (inReset) begin
      flags_reg <= 3'b111;
    end else if (wrFlags) begin
      flags_reg <= wByte[2:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (inReset) begin
      option_reg   <= `RVIP_OPT_RST;
      ramMap_reg   <= `RVIP_RAMMAP_RST;
      rate_reg     <= `RVIP_RATE_RST;
      wdEnable_reg <= !cfg_reg[`RVIP_CFG_WDDIS];
    end else begin
      if (wrOpt) begin
        option_reg <= {wByte[7:3], 1'b0, wByte[1:0]};
      end
      if (wrMap) begin
        ramMap_reg <= wByte;
      end
      if (wrRate) begin
        rate_reg <= wByte;
      end
    end
  end

  // Mode bits come from the pins on the edge after system reset release
  logic modeSpec;
  logic modeA;
  assign modeSpec = !syncB_reg[4];
  assign modeA    = syncB_reg[3];
  always_ff @(posedge mclk) begin
    if (srstDly_reg && !srst) begin
      modeBits_reg <= {modeSpec && !modeA, modeSpec, modeA};
    end else if (srst) begin
      modeBits_reg <= 3'b000;
    end else if (wrPrio && flags_reg[`RVIP_FLG_IMASK] &&
                 prio_reg[`RVIP_PRIO_SPEC]) begin
      modeBits_reg <= wByte[7:5];
    end
  end

  always_ff @(posedge mclk) begin
    if (inReset) begin
      prioLow_reg <= `RVIP_PRIO_LOW_RST;
    end else if (wrPrio && flags_reg[`RVIP_FLG_IMASK]) begin
      prioLow_reg <= wByte[4:0];
    end
  end
  assign prio_reg = {modeBits_reg, prioLow_reg};

  always_ff @(posedge mclk) begin
    periphInit       <= inReset;
    timerCountInit   <= `RVIP_TCNT_RST;
    compareInit      <= `RVIP_OC_RST;
    serialStatusInit <= `RVIP_SSTAT_RST;
    stopInhibit      <= inReset || flags_reg[`RVIP_FLG_STOPDIS];
    wdEnable         <= !inReset && wdEnable_reg;
    wdRate           <= inReset ? 2'b00 : option_reg[1:0];
    clockLossEnable  <= !inReset && option_reg[`RVIP_OPT_CME];
    oscStartupDelay  <= inReset || option_reg[`RVIP_OPT_DLY];
  end

  // ------------------------------------------------------------
  // AXI4-Lite read path
  // ------------------------------------------------------------
  logic [31:0] rdNext;
  logic        rdHit;
  always_comb begin
    rdHit  = 1'b1;
    rdNext = 32'h0000_0000;
    case ({araddr[7:2], 2'b00})
      `RVIP_OFF_CFG:    rdNext[7:0] = cfg_reg;
      `RVIP_OFF_PRIO:   rdNext[7:0] = prio_reg;
      `RVIP_OFF_FLAGS:  rdNext[2:0] = flags_reg;
      `RVIP_OFF_STATUS: rdNext[19:0] = {cause_reg, state_reg, vecNext};
      `RVIP_OFF_OPTION: rdNext[7:0] = option_reg;
      `RVIP_OFF_RAMMAP: rdNext[7:0] = ramMap_reg;
      `RVIP_OFF_RATE:   rdNext[7:0] = rate_reg;
      default:          rdHit = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= 2'b00;
    end else begin
      arready <= !rvalid && !(arvalid && arready);
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata  <= rdNext;
        rresp  <= rdHit ? 2'b00 : 2'b10;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Interrupt priority
  // ------------------------------------------------------------
  logic [3:0] psel;
  logic [3:0] promIdx;
  assign psel = prio_reg[3:0];
  always_comb begin
    if (psel >= 4'h8) begin
      promIdx = psel - 4'h6;
    end else if (psel == 4'h7) begin
      promIdx = 4'h1;
    end else if (psel >= 4'h5) begin
      promIdx = 4'h0;
    end else begin
      promIdx = psel + 4'hA;
    end
  end

  logic [14:0] live;
  logic [14:0] below;
  logic [4:0]  selNext;
  assign live = flags_reg[`RVIP_FLG_IMASK] ? 15'h0000 : maskReq;
  assign below[0] = 1'b0;
  genvar gi;
  generate
    for (gi = 1; gi < 15; gi++) begin : gPrio
      assign below[gi] = below[gi-1] || live[gi-1];
    end
  endgenerate

  always_comb begin
    selNext = `RVIP_SEL_NONE;
    if (nonmaskablePinRequest && !flags_reg[`RVIP_FLG_XMASK]) begin
      selNext = `RVIP_SEL_NMI;
    end else if (illegalOp) begin
      selNext = `RVIP_SEL_ILL;
    end else if (softwareTrap) begin
      selNext = `RVIP_SEL_SWI;
    end else if (live[promIdx]) begin
      selNext = {1'b0, promIdx};
    end else begin
      for (int i = 14; i >= 0; i--) begin
        if (live[i] && !below[i]) begin
          selNext = 5'(i);
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (inReset) begin
      intSel   <= `RVIP_SEL_NONE;
      intValid <= 1'b0;
    end else begin
      intSel   <= selNext;
      intValid <= selNext != `RVIP_SEL_NONE;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  sequence sFetch3;
    vectorFetch [*3] ##1 !vectorFetch;
  endsequence
  sequence sHoldDone;
    cpuReset ##1 !cpuReset;
  endsequence

  a_fetch_three: assert property ($rose(vectorFetch) |-> sFetch3)
    else $error("vector fetch not three cycles");
  a_fetch_after: assert property (sHoldDone |-> vectorFetch)
    else $error("fetch does not follow reset hold");
  a_vector_pick: assert property (vectorFetch |->
    vectorAddr[7:0] == ($past(cause_reg) == rvip_pkg::RVIP_CLK ? 8'hFC :
    $past(cause_reg) == rvip_pkg::RVIP_WD ? 8'hFA : 8'hFE))
    else $error("wrong vector low byte for cause");
  a_vector_mode: assert property (vectorFetch |->
    vectorAddr[15:8] == (prio_reg[6] ? 8'hBF : 8'hFF))
    else $error("wrong vector page for mode");
  a_wd_gate: assert property (state_reg == rvip_pkg::RVIP_RUN && wdSync
    && !wdEnable_reg && !porSync && !trigClk |=>
    state_reg == rvip_pkg::RVIP_RUN)
    else $error("disabled watchdog forced reset");
  a_mask_reset: assert property ($fell(cpuReset) |->
    flags_reg == 3'b111 && stopInhibit)
    else $error("masks not set out of reset");
  a_map_reset: assert property ($fell(cpuReset) |->
    ramMap_reg == 8'h01 && rate_reg == 8'h04)
    else $error("map or rate reset wrong");
  a_psel_reset: assert property ($fell(cpuReset) |->
    prio_reg[3:0] == 4'b0110 && !option_reg[5] && option_reg[4])
    else $error("priority select reset wrong");
  a_prio_lock: assert property (wrPrio && !flags_reg[0] && !inReset |=>
    $stable(prio_reg))
    else $error("priority written while unmasked");
  a_prom_first: assert property (!inReset && selNext < 5'h10 &&
    live[promIdx] |=> intSel == {1'b0, $past(promIdx)})
    else $error("promoted source not served first");
  a_nmi_first: assert property (!inReset && nonmaskablePinRequest &&
    !flags_reg[1] |=> intSel == 5'h10)
    else $error("pin request not above maskable");
endmodule

// ---- rvip_cpu_model.sv ----
// CPU-side partner: records each reset vector fetch burst
`timescale 1ns/1ns
module rvip_cpu_model (
  input  wire logic        mclk,
  input  wire logic        cpuReset,
  input  wire logic        vectorFetch,
  input  wire logic [15:0] vectorAddr,
  output logic      [3:0]  fetchLen,
  output logic      [15:0] fetchVec,
  output logic      [7:0]  fetchNum
);
  logic [3:0] fetchCnt_reg;
  initial fetchNum = 8'h00;
  // ----------------------------------------------------------
  // Fetch burst length and vector
  // ----------------------------------------------------------
  always @(posedge mclk) begin
    if (cpuReset) begin
      fetchCnt_reg <= 4'h0;
    end else if (vectorFetch) begin
      fetchCnt_reg <= fetchCnt_reg + 4'h1;
      fetchVec     <= vectorAddr;
    end else if (fetchCnt_reg != 4'h0) begin
      fetchLen     <= fetchCnt_reg;
      fetchNum     <= fetchNum + 8'h01;
      fetchCnt_reg <= 4'h0;
    end
  end
endmodule

// ---- test_reset_vector_and_interrupt_priority.sv ----
// Self-checking bench for the reset vector and priority logic
`timescale 1ns/1ns
module test_reset_vector_and_interrupt_priority;
  logic        mclk = 0, srst = 1, porPin = 0, clockLossReq = 0;
  logic        watchdogTimeout = 0, modePinA = 0, modePinB = 1;
  logic [14:0] maskReq = 0;
  logic        nonmaskablePinRequest = 0, illegalOp = 0, softwareTrap = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0, rdata, seed, r;
  logic [3:0]  wstrb = 4'hF, fetchLen;
  logic        awready, wready, bvalid, arready, rvalid, cpuReset;
  logic        vectorFetch, intValid, stopInhibit, wdEnable, periphInit;
  logic        clockLossEnable, oscStartupDelay;
  logic [1:0]  bresp, rresp, wdRate;
  logic [15:0] vectorAddr, timerCountInit, compareInit, fetchVec;
  logic [4:0]  intSel;
  logic [7:0]  serialStatusInit, fetchNum, n;
  int          errors = 0, checks = 0, cyc = 0;
  logic [7:0]  offs [6] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18};
  logic [31:0] rv [6] = '{32'h0F, 32'h06, 32'h07, 32'h10, 32'h01, 32'h04};
  rvip_core i_rvip_core (.mclk, .srst, .porPin, .clockLossReq,
    .watchdogTimeout, .modePinA, .modePinB, .maskReq,
    .nonmaskablePinRequest, .illegalOp, .softwareTrap, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .cpuReset, .vectorFetch, .vectorAddr, .intValid, .intSel, .stopInhibit,
    .wdEnable, .wdRate, .clockLossEnable, .oscStartupDelay, .periphInit,
    .timerCountInit, .compareInit, .serialStatusInit);
  rvip_cpu_model i_rvip_cpu_model (.mclk, .cpuReset, .vectorFetch,
    .vectorAddr, .fetchLen, .fetchVec, .fetchNum);
  always #5 mclk = ~mclk;
  // ----------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------
  task automatic final_report;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      final_report;
    end
  end
  task automatic chk(input string nm, input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    chk("bresp", 32'(bresp), 32'h0);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    @(posedge mclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    chk("rdata", rdata, e);
    chk("rresp", 32'(rresp), 32'(er));
    rready <= 1'b0;
  endtask
  task automatic wfetch(input logic [15:0] v);
    n = fetchNum;
    while (fetchNum === n) @(posedge mclk);
    chk("vector", 32'(fetchVec), 32'(v));
    chk("fetchLen", 32'(fetchLen), 32'h3);
  endtask
  task automatic pulse(input int w);
    repeat (3) @(posedge mclk);
    {porPin, clockLossReq, watchdogTimeout} <= 3'b000;
    repeat (w) @(posedge mclk);
  endtask
  function automatic logic [5:0] expSel(logic [14:0] q, logic [3:0] p,
                                        logic im, xm, nm, il, sw);
    int top;
    top = (p < 5) ? 10 + p : (p < 7) ? 0 : p - 6;
    if (nm && !xm) return 6'h30;
    if (il) return 6'h31;
    if (sw) return 6'h32;
    if (!im && q[top]) return {1'b1, 5'(top)};
    if (!im) for (int i = 0; i < 15; i++) if (q[i]) return {1'b1, 5'(i)};
    return 6'h1F;
  endfunction
  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    logic x;
    seed = 32'h1540;
    repeat (10) @(posedge mclk);
    chk("cpuReset", 32'(cpuReset), 32'h1);
    chk("periphInit", 32'(periphInit), 32'h1);
    srst <= 1'b0;
    wfetch(16'hFFFE);
    chk("periphInit", 32'(periphInit), 32'h0);
    chk("stopInh", 32'(stopInhibit), 32'h1);
    chk("wdEnable", 32'({wdEnable, wdRate}), 32'h0);
    chk("cme", 32'({clockLossEnable, oscStartupDelay}), 32'h1);
    chk("tcnt", 32'(timerCountInit), 32'h0000);
    chk("cmp", 32'(compareInit), 32'h0000_FFFF);
    chk("sstat", 32'(serialStatusInit), 32'hC0);
    for (int i = 0; i < 6; i++) rd(offs[i], rv[i], 2'b00);
    rd(8'h0C, 32'h0002_FFFE, 2'b00);
    rd(8'h1C, 32'h0, 2'b10);
    maskReq <= 15'h7FFF;
    nonmaskablePinRequest <= 1'b1;
    repeat (2) @(posedge mclk);
    chk("intSel", 32'({intValid, intSel}), 32'h1F);
    for (int p = 0; p < 16; p++) begin
      wr(8'h08, 32'h07);
      wr(8'h04, 32'(p));
      x = 1'($random(seed));
      wr(8'h08, {29'h0, 1'b1, x, 1'b0});
      wr(8'h04, 32'(p ^ 1));
      rd(8'h04, 32'(p), 2'b00);
      repeat (6) begin
        r = $random(seed);
        maskReq <= r[23:9];
        nonmaskablePinRequest <= (r[2:0] == 0);
        illegalOp <= (r[5:3] == 0);
        softwareTrap <= (r[8:6] == 0);
        repeat (2) @(posedge mclk);
        chk("intSel", 32'({intValid, intSel}),
            32'(expSel(r[23:9], p[3:0], 1'b0, x, r[2:0] == 0,
            r[5:3] == 0, r[8:6] == 0)));
      end
    end
    {maskReq, nonmaskablePinRequest, illegalOp, softwareTrap} <= 0;
    wr(8'h10, 32'h18);
    n = fetchNum;
    watchdogTimeout <= 1'b1;
    pulse(20);
    chk("noReset", 32'(fetchNum), 32'(n));
    clockLossReq <= 1'b1;
    pulse(0);
    wfetch(16'hFFFC);
    rd(8'h0C, 32'h0006_FFFC, 2'b00);
    chk("cme", 32'(clockLossEnable), 32'h0);
    wr(8'h00, 32'h0B);
    porPin <= 1'b1;
    pulse(0);
    wfetch(16'hFFFE);
    chk("wdEnable", 32'(wdEnable), 32'h1);
    watchdogTimeout <= 1'b1;
    pulse(0);
    wfetch(16'hFFFA);
    rd(8'h0C, 32'h000A_FFFA, 2'b00);
    modePinB <= 1'b0;
    srst <= 1'b1;
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
    wfetch(16'hBFFE);
    rd(8'h04, 32'hC6, 2'b00);
    wr(8'h04, 32'h66);
    rd(8'h04, 32'h66, 2'b00);
    final_report;
  end
endmodule
